// file: design/gpit_defines.svh
// Register offsets, control bit positions, reset values and timing constants
`ifndef GPIT_DEFINES_SVH
`define GPIT_DEFINES_SVH

`define GPIT_COUNT_OFFSET     8'h00
`define GPIT_PERIOD_OFFSET    8'h02
`define GPIT_CONTROL_OFFSET   8'h04
`define GPIT_STATUS_OFFSET    8'h06

`define GPIT_CTL_TIMER_ON     15
`define GPIT_CTL_STOP_IDLE    13
`define GPIT_CTL_GATE_EN      6
`define GPIT_CTL_PRESC_HI     5
`define GPIT_CTL_PRESC_LO     4
`define GPIT_CTL_EXT_SYNC     2
`define GPIT_CTL_CLK_SRC      1
`define GPIT_CTL_MASK         16'ha076

`define GPIT_STAT_MATCH       0
`define GPIT_STAT_GATE_FALL   1

`define GPIT_COUNT_RESET      16'h0000
`define GPIT_PERIOD_RESET     16'hffff
`define GPIT_CONTROL_RESET    16'h0000

`define GPIT_CLK_MHZ          100
`define GPIT_TCY_NS           40
`define GPIT_TCY_CYCLES       ((`GPIT_TCY_NS * `GPIT_CLK_MHZ) / 1000)

`endif

// file: design/gpit_pkg.sv
// Types shared by the interval timer
package gpit_pkg;
	typedef enum logic [1:0] {
		GPIT_DIV_1   = 2'b00,
		GPIT_DIV_8   = 2'b01,
		GPIT_DIV_64  = 2'b10,
		GPIT_DIV_256 = 2'b11
	} gpit_presc_t;

	typedef enum logic [1:0] {
		GPIT_SRC_IDLE  = 2'b00,
		GPIT_SRC_TCY   = 2'b01,
		GPIT_SRC_SYNC  = 2'b10,
		GPIT_SRC_ASYNC = 2'b11
	} gpit_src_t;
endpackage

// file: design/gpit_prescaler.sv
// Counting-clock prescaler with selectable divide ratio
`timescale 1ns/1ps
`default_nettype none
module gpit_prescaler
	import gpit_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Control
	input  wire logic             run,
	input  wire logic             clear,
	input  wire gpit_presc_t      ratio,
	input  wire logic             tick_in,
	// Result
	output logic                  tick_out
);
	logic [WIDTH-1:0] div_reg;
	logic [WIDTH-1:0] div_next;

	function automatic logic [WIDTH-1:0] terminal(input gpit_presc_t r);
		case (r)
			GPIT_DIV_8:   terminal = WIDTH'(7);
			GPIT_DIV_64:  terminal = WIDTH'(63);
			GPIT_DIV_256: terminal = WIDTH'(255);
			default:      terminal = WIDTH'(0);
		endcase
	endfunction

	always_comb begin
		div_next = div_reg;
		tick_out = 1'b0;
		if (run) begin
			if (clear) begin
				div_next = '0;
			end else if (tick_in) begin
				if (div_reg >= terminal(ratio)) begin
					div_next = '0;
					tick_out = 1'b1;
				end else begin
					div_next = div_reg + WIDTH'(1);
				end
			end
		end
	end

	// Counter holds while stopped, even across clearing events
	always_ff @(posedge clk) begin
		if (reset) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end
endmodule
`default_nettype wire

// file: design/gpit_timer.sv
// 16-bit gated, prescaled interval timer with period compare
`timescale 1ns/1ps
`default_nettype none
`include "gpit_defines.svh"

// Summary of operation
// - Timer mode counts Tcy, wraps on period match
// - Timer mode halts in idle if stop_in_idle
// - Sync counter counts resynchronised external rising edges
// - Sync counter halts in idle if stop_in_idle
// - Async counter counts the same resynchronised external rising edges, and keeps counting in sleep
// - Async counter stops in idle if stop_in_idle
// - Gated mode counts Tcy while gate high
// - Gated mode halts in idle if stop_in_idle
// - Prescaler input is Tcy or external clock
// - Divide by 1, 8, 64 or 256
// - Count/control write or reset clears prescaler
// - Stopped timer does not clear prescaler
// - Control write keeps count; count write replaces
// - Interrupt on period match and gate fall
// - external_sync_select picks async or synchronised counting
// - Match flag sticky until software clears it
// - Gate falling edge sets flag in gated mode
module gpit_timer
	import gpit_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [15:0] rdata,
	// Processor state
	input  wire logic        cpu_idle,
	input  wire logic        cpu_sleep,
	// External clock or gate pin
	input  wire logic        gate_clock_input_pin,
	// Events
	output logic             timer_irq,
	output logic             period_match_flag
);
	// Synchroniser and edge history for the external pin
	logic        pin_s1_reg;
	logic        pin_s2_reg;
	logic        pin_prev_reg;
	logic        pin_s1_next;
	logic        pin_s2_next;
	logic        pin_prev_next;

	// Instruction-cycle divider
	logic [7:0]  tcy_cnt_reg;
	logic [7:0]  tcy_cnt_next;
	logic        tcy_tick;

	// Register file and counter
	logic [15:0] count_register;
	logic [15:0] count_next;
	logic [15:0] period_register;
	logic [15:0] period_next;
	logic [15:0] timer_control_register;
	logic [15:0] control_next;
	logic        match_flag_reg;
	logic        match_flag_next;
	logic        gate_flag_reg;
	logic        gate_flag_next;
	logic        irq_reg;
	logic        irq_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;

	// Decoded controls
	logic        timer_on;
	logic        stop_in_idle;
	logic        gate_accumulate_enable;
	logic        external_sync_select;
	logic        clock_source_select;
	gpit_presc_t prescale_select;
	gpit_src_t   source;

	// Datapath strobes
	logic        wr_count;
	logic        wr_period;
	logic        wr_control;
	logic        wr_status;
	logic        rise_edge;
	logic        fall_edge;
	logic        raw_tick;
	logic        presc_tick;
	logic        halted;
	logic        match_now;
	logic        gate_fall_evt;

	localparam logic [7:0] TCY_LAST = 8'(`GPIT_TCY_CYCLES - 1);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign timer_on               = timer_control_register[`GPIT_CTL_TIMER_ON];
	assign stop_in_idle           = timer_control_register[`GPIT_CTL_STOP_IDLE];
	assign gate_accumulate_enable = timer_control_register[`GPIT_CTL_GATE_EN];
	assign external_sync_select   = timer_control_register[`GPIT_CTL_EXT_SYNC];
	assign clock_source_select    = timer_control_register[`GPIT_CTL_CLK_SRC];
	assign prescale_select        = gpit_presc_t'(timer_control_register[`GPIT_CTL_PRESC_HI:`GPIT_CTL_PRESC_LO]);

	// Address decode
	always_comb begin
		wr_count   = 1'b0;
		wr_period  = 1'b0;
		wr_control = 1'b0;
		wr_status  = 1'b0;
		if (wr_en && hit(addr, `GPIT_COUNT_OFFSET)) begin
			wr_count = 1'b1;
		end else if (wr_en && hit(addr, `GPIT_PERIOD_OFFSET)) begin
			wr_period = 1'b1;
		end else if (wr_en && hit(addr, `GPIT_CONTROL_OFFSET)) begin
			wr_control = 1'b1;
		end else if (wr_en && hit(addr, `GPIT_STATUS_OFFSET)) begin
			wr_status = 1'b1;
		end
	end

	// Pin synchroniser; edges seen only after the second stage
	always_comb begin
		pin_s1_next   = gate_clock_input_pin;
		pin_s2_next   = pin_s1_reg;
		pin_prev_next = pin_s2_reg;
	end

	assign rise_edge = pin_s2_reg & ~pin_prev_reg;
	assign fall_edge = ~pin_s2_reg & pin_prev_reg;

	// Instruction cycle is Fosc/4
	always_comb begin
		tcy_tick     = (tcy_cnt_reg == TCY_LAST);
		tcy_cnt_next = tcy_tick ? 8'h00 : tcy_cnt_reg + 8'h01;
	end

	// Counting source selection
	always_comb begin
		if (!timer_on) begin
			source = GPIT_SRC_IDLE;
		end else if (!clock_source_select) begin
			source = GPIT_SRC_TCY;
		end else if (external_sync_select) begin
			source = GPIT_SRC_SYNC;
		end else begin
			source = GPIT_SRC_ASYNC;
		end
	end

	// Async mode keeps running in sleep; all modes obey idle stop
	always_comb begin
		halted = 1'b0;
		if (cpu_idle && stop_in_idle) begin
			halted = 1'b1;
		end else if (cpu_sleep && source != GPIT_SRC_ASYNC) begin
			halted = 1'b1;
		end
	end

	always_comb begin
		raw_tick = 1'b0;
		case (source)
			GPIT_SRC_TCY: begin
				if (gate_accumulate_enable) begin
					raw_tick = tcy_tick & pin_s2_reg;
				end else begin
					raw_tick = tcy_tick;
				end
			end
			GPIT_SRC_SYNC: begin
				raw_tick = rise_edge;
			end
			GPIT_SRC_ASYNC: begin
				raw_tick = rise_edge;
			end
			default: begin
				raw_tick = 1'b0;
			end
		endcase
		if (halted) begin
			raw_tick = 1'b0;
		end
	end

	gpit_prescaler #(
		.WIDTH (8)
	) u_prescaler (
		.clk      (clk),
		.reset    (reset),
		.run      (timer_on),
		.clear    (wr_count | wr_control),
		.ratio    (prescale_select),
		.tick_in  (raw_tick),
		.tick_out (presc_tick)
	);

	assign match_now     = presc_tick && (count_register == period_register);
	assign gate_fall_evt = timer_on && gate_accumulate_enable && !clock_source_select && fall_edge && !halted;

	// Registers, counter and flags
	always_comb begin
		count_next      = count_register;
		period_next     = period_register;
		control_next    = timer_control_register;
		match_flag_next = match_flag_reg;
		gate_flag_next  = gate_flag_reg;
		rdata_next      = 16'h0000;
		if (wr_count) begin
			count_next = wdata;
		end else if (match_now) begin
			count_next = 16'h0000;
		end else if (presc_tick) begin
			count_next = count_register + 16'h0001;
		end
		if (wr_period) begin
			period_next = wdata;
		end
		if (wr_control) begin
			control_next = wdata & `GPIT_CTL_MASK;
		end
		// Write one to clear; a same-cycle event wins
		if (wr_status && wdata[`GPIT_STAT_MATCH]) begin
			match_flag_next = 1'b0;
		end
		if (wr_status && wdata[`GPIT_STAT_GATE_FALL]) begin
			gate_flag_next = 1'b0;
		end
		if (match_now) begin
			match_flag_next = 1'b1;
		end
		if (gate_fall_evt) begin
			gate_flag_next = 1'b1;
		end
		if (rd_en) begin
			if (hit(addr, `GPIT_COUNT_OFFSET)) begin
				rdata_next = count_register;
			end else if (hit(addr, `GPIT_PERIOD_OFFSET)) begin
				rdata_next = period_register;
			end else if (hit(addr, `GPIT_CONTROL_OFFSET)) begin
				rdata_next = timer_control_register;
			end else if (hit(addr, `GPIT_STATUS_OFFSET)) begin
				rdata_next = {14'h0000, gate_flag_reg, match_flag_reg};
			end
		end
		irq_next = match_flag_next | gate_flag_next;
	end

	// Pin synchroniser and edge history; idles low so reset makes no false edge
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_s1_reg   <= 1'b0;
			pin_s2_reg   <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			pin_s1_reg   <= pin_s1_next;
			pin_s2_reg   <= pin_s2_next;
			pin_prev_reg <= pin_prev_next;
		end
	end

	// Instruction-cycle divider runs freely from reset
	always_ff @(posedge clk) begin
		if (reset) begin
			tcy_cnt_reg <= 8'h00;
		end else begin
			tcy_cnt_reg <= tcy_cnt_next;
		end
	end

	// Registers, counter, flags and read data
	always_ff @(posedge clk) begin
		if (reset) begin
			count_register         <= `GPIT_COUNT_RESET;
			period_register        <= `GPIT_PERIOD_RESET;
			timer_control_register <= `GPIT_CONTROL_RESET;
			match_flag_reg         <= 1'b0;
			gate_flag_reg          <= 1'b0;
			irq_reg                <= 1'b0;
			rdata_reg              <= 16'h0000;
		end else begin
			count_register         <= count_next;
			period_register        <= period_next;
			timer_control_register <= control_next;
			match_flag_reg         <= match_flag_next;
			gate_flag_reg          <= gate_flag_next;
			irq_reg                <= irq_next;
			rdata_reg              <= rdata_next;
		end
	end

	assign rdata             = rdata_reg;
	assign timer_irq         = irq_reg;
	assign period_match_flag = match_flag_reg;
endmodule
`default_nettype wire

// file: tb/gpit_pin_model.sv
// External clock and gate source for the timer pin
`timescale 1ns/1ps
`default_nettype none
module gpit_pin_model (
	// Clock
	input  wire logic clk,
	// Pin
	output logic      pin
);
	// Idle low between bursts; each level lasts whole clk cycles for the sampler
	initial pin = 1'b0;
	task automatic drive(input logic v, input int len);
		pin <= v;
		repeat (len) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: tb/gpit_timer_chk.sv
// Port checker for the interval timer
`timescale 1ns/1ps
`default_nettype none
module gpit_timer_chk (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [15:0] rdata,
	// Pin and events
	input  wire logic        gate_clock_input_pin,
	input  wire logic        timer_irq,
	input  wire logic        period_match_flag
);
	logic clr;
	assign clr = wr_en && addr == 8'h06 && wdata[0];
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_wr_rd(a);
		wr_en && addr == a ##2 rd_en && addr == a;
	endsequence
	property p_rd_idle; !$past(rd_en) |-> rdata == 16'h0000; endproperty
	property p_unmapped; rd_en && addr > 8'h07 |=> rdata == 16'h0000; endproperty
	property p_per_rd; s_wr_rd(8'h02) |=> rdata == $past(wdata, 3); endproperty
	property p_ctl_rd; s_wr_rd(8'h04) |=> rdata == ($past(wdata, 3) & 16'ha076); endproperty
	property p_sticky; period_match_flag && !clr |=> period_match_flag; endproperty
	property p_irq; period_match_flag |-> timer_irq; endproperty
	property p_clr; $fell(period_match_flag) |-> $past(clr); endproperty
	property p_gate; $rose(timer_irq) && !period_match_flag |-> !$past(gate_clock_input_pin, 2); endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata set without read");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_per_rd: assert property (p_per_rd) else $error("period readback wrong");
	a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
	a_sticky: assert property (p_sticky) else $error("match flag dropped");
	a_irq: assert property (p_irq) else $error("irq missing with flag");
	a_clr: assert property (p_clr) else $error("flag cleared without write");
	a_gate: assert property (p_gate) else $error("irq without gate fall");
endmodule
bind gpit_timer gpit_timer_chk u_gpit_timer_chk (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .gate_clock_input_pin(gate_clock_input_pin),
	.timer_irq(timer_irq), .period_match_flag(period_match_flag));
`default_nettype wire

// file: tb/gpit_timer_tb_top.sv
// Self-checking bench for the interval timer
`timescale 1ns/1ps
`default_nettype none
module gpit_timer_tb_top;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [15:0] rdata;
	logic        cpu_idle = 1'b0;
	logic        cpu_sleep = 1'b0;
	logic        pin;
	logic        timer_irq;
	logic        period_match_flag;
	logic [15:0] v;
	int          err_count = 0;
	int          compares = 0;
	int          dv[4] = '{1, 8, 64, 256};
	always #5 clk = ~clk;
	gpit_timer u_gpit_timer (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
		.gate_clock_input_pin(pin), .timer_irq(timer_irq), .period_match_flag(period_match_flag));
	gpit_pin_model u_gpit_pin_model (.clk(clk), .pin(pin));
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input string n, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] got);
		compares++;
		if (((got >= lo) && (got <= hi)) !== 1'b1) begin
			err_count++;
			$display("[FAIL] %s expected %h..%h seen %h", n, lo, hi, got);
		end
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rc(input string n, input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
		@(posedge clk);
		chk(n, lo, hi, v);
	endtask
	// Whole external clock periods of six cycles, pin left low
	task automatic pulses(input int n);
		repeat (n) begin
			u_gpit_pin_model.drive(1'b1, 3);
			u_gpit_pin_model.drive(1'b0, 3);
		end
	endtask
	task automatic wrap_up;
		$display("Compares %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#500000;
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rc("count", 8'h00, 16'h0000, 16'h0000);
		rc("period", 8'h02, 16'hffff, 16'hffff);
		rc("control", 8'h04, 16'h0000, 16'h0000);
		rc("unmapped", 8'h08, 16'h0000, 16'h0000);
		wr(8'h04, 16'h7fff);
		rc("control mask", 8'h04, 16'h2076, 16'h2076);
		wr(8'h00, 16'h1234);
		wr(8'h04, 16'h0000);
		rc("count kept", 8'h00, 16'h1234, 16'h1234);
		wr(8'h02, 16'h0003);
		rc("period", 8'h02, 16'h0003, 16'h0003);
		wr(8'h00, 16'h0000);
		wr(8'h04, 16'h8000);
		repeat (12) rc("wrap count", 8'h00, 16'h0000, 16'h0003);
		chk("match flag", 16'h0001, 16'h0001, {15'h0, period_match_flag});
		chk("irq", 16'h0001, 16'h0001, {15'h0, timer_irq});
		wr(8'h04, 16'h0000);
		rc("status", 8'h06, 16'h0001, 16'h0001);
		wr(8'h06, 16'h0003);
		chk("flag cleared", 16'h0000, 16'h0000, {15'h0, period_match_flag});
		wr(8'h02, 16'hffff);
		for (int k = 0; k < 4; k++) begin
			wr(8'h00, 16'h0000);
			wr(8'h04, 16'h8000 | (16'(k) << 4));
			repeat (2048) @(posedge clk);
			wr(8'h04, 16'h0000);
			rc("prescaled", 8'h00, 16'(512 / dv[k] - 1), 16'(512 / dv[k] + 1));
		end
		for (int s = 0; s < 2; s++) begin
			cpu_idle <= 1'b1;
			wr(8'h00, 16'h0000);
			wr(8'h04, 16'h8000 | (16'(s) << 13));
			repeat (400) @(posedge clk);
			wr(8'h04, 16'h0000);
			cpu_idle <= 1'b0;
			rc("idle count", 8'h00, s ? 16'h0000 : 16'h0063, s ? 16'h0000 : 16'h0067);
		end
		for (int m = 0; m < 4; m++) begin
			wr(8'h00, 16'h0000);
			wr(8'h04, 16'h8002 | (16'(m & 1) << 2));
			cpu_sleep <= m[1];
			repeat (10) begin
				u_gpit_pin_model.drive(1'b1, 3);
				u_gpit_pin_model.drive(1'b0, 3);
			end
			repeat (6) @(posedge clk);
			wr(8'h04, 16'h0000);
			cpu_sleep <= 1'b0;
			rc("ext count", 8'h00, m == 3 ? 16'h0000 : 16'h000a, m == 3 ? 16'h0000 : 16'h000a);
		end
		// Residue of five edges is dropped by the count write, so ten edges give no tick
		wr(8'h00, 16'h0000);
		wr(8'h04, 16'h8016);
		pulses(5);
		wr(8'h00, 16'h0000);
		pulses(5);
		rc("presc cleared", 8'h00, 16'h0000, 16'h0000);
		pulses(3);
		rc("presc by 8", 8'h00, 16'h0001, 16'h0001);
		wr(8'h04, 16'h0000);
		wr(8'h00, 16'h0000);
		wr(8'h04, 16'h8040);
		u_gpit_pin_model.drive(1'b1, 40);
		u_gpit_pin_model.drive(1'b0, 8);
		wr(8'h04, 16'h0000);
		rc("gated count", 8'h00, 16'h0009, 16'h000b);
		chk("gate irq", 16'h0001, 16'h0001, {15'h0, timer_irq});
		rc("gate status", 8'h06, 16'h0002, 16'h0002);
		wr(8'h06, 16'h0002);
		chk("irq cleared", 16'h0000, 16'h0000, {15'h0, timer_irq});
		wrap_up();
	end
endmodule
`default_nettype wire
